//--- adc_serial_port_pkg.sv
package adc_serial_port_pkg;

    // ==========================================================
    // Word format
    // ==========================================================
    localparam int WORD_BITS = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int BIT_COUNT_W = 5;

    // ==========================================================
    // Control word layout
    // ==========================================================
    localparam int CTRL_FLAG_BIT = 15;
    localparam int CTRL_ADDR_MSB = 10;
    localparam int CTRL_ADDR_LSB = 8;
    localparam logic [2:0] ADDR_CTRL_A = 3'h0;
    localparam logic [2:0] ADDR_CTRL_B = 3'h1;
    localparam logic [2:0] ADDR_CTRL_C = 3'h2;

    // Control register A: master divider and serial divider select
    localparam int MDIV_MSB = 4;
    localparam int MDIV_LSB = 2;
    localparam int SDIV_MSB = 1;
    localparam int SDIV_LSB = 0;
    // Control register B: conversion rate select
    localparam int RATE_MSB = 1;
    localparam int RATE_LSB = 0;
    // Control register C: reference level select
    localparam int REF_SEL_BIT = 7;

    // Reset values
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [7:0] CTRL_C_RESET = 8'h00;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ = 40000000;
    localparam int FASTEST_RATE_HZ = 64000;
    localparam int SAMPLE_CYCLES_FASTEST = CLK_HZ / FASTEST_RATE_HZ;
    localparam logic [7:0] SCLK_BASE_DIV = 8'h08;
    localparam int BIT_PERIOD_W = 10;

endpackage : adc_serial_port_pkg

//--- word_fifo.sv
`timescale 1ns/100ps

module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Filling side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // Draining side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
            $error("word_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
    logic full;
    logic empty;
    logic doWrite;
    logic doRead;

    assign doWrite = inValid && !full;
    assign doRead = outReady && !empty;
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr];

    // ==========================================================
    // Storage
    // ==========================================================
    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers, occupancy and registered flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            full <= 1'b0;
            empty <= 1'b1;
        end else begin
            if (doWrite) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doWrite && !doRead) begin
                count <= count + 1'b1;
                full <= (count == (PW+1)'(DEPTH - 1));
                empty <= 1'b0;
            end else if (doRead && !doWrite) begin
                count <= count - 1'b1;
                full <= 1'b0;
                empty <= (count == (PW+1)'(1));
            end
        end
    end

endmodule : word_fifo

//--- bit_clock_divider.sv
`timescale 1ns/100ps

module bit_clock_divider #(
    parameter int PW = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic [PW-1:0] period,
    // Bit clock and its edge events
    output logic bitClock,
    output logic riseTick,
    output logic fallTick
);
    logic [PW-1:0] phase;
    logic [PW-1:0] halfLast;

    initial begin
        if (PW < 3) begin
            $error("bit_clock_divider: period width too small");
        end
    end

    assign halfLast = (period >> 1) - 1'b1;

    // ==========================================================
    // Toggle every half period; held low and reset when stopped
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= '0;
            bitClock <= 1'b0;
            riseTick <= 1'b0;
            fallTick <= 1'b0;
        end else if (!run) begin
            phase <= '0;
            bitClock <= 1'b0;
            riseTick <= 1'b0;
            fallTick <= 1'b0;
        end else if (phase >= halfLast) begin
            phase <= '0;
            bitClock <= !bitClock;
            riseTick <= !bitClock;
            fallTick <= bitClock;
        end else begin
            phase <= phase + 1'b1;
            riseTick <= 1'b0;
            fallTick <= 1'b0;
        end
    end

endmodule : bit_clock_divider

//--- adc_framed_serial_port.sv
`timescale 1ns/100ps

// Function
// - Bit clock output is master clock over master times serial divider.
// - Data and control words shift out, bits change on bit clock rise.
// - Serial output floats when idle or when the port is disabled.
// - Output frame sync is one bit period, just before each MSB.
// - Output frame sync changes on rise; floats while port disabled.
// - Partner gives input frame sync one period before MSB; sampled on fall.
// - Input frame sync ignored while port disabled.
// - Partner gives input bits; each captured on bit clock fall.
// - Serial input ignored while port disabled.
// - Port enable is asynchronous; disabled means outputs float, inputs ignored.
// - Bit clock stopped while port disabled.
// - Control and data registers keep values across disable, except a transmit FIFO head word popped by txStart in the first disabled cycle.
// - Serial counters and other port state restart after disable; the sample rate timer keeps running.
// - Active-low reset clears control registers and all logic except the transmit FIFO word storage.
// - Control register C bit 7 selects reference output level.
// - Four conversion rates: 64, 32, 16 and 8 kHz.
module adc_framed_serial_port
    import adc_serial_port_pkg::*;
#(
    parameter int WIDTH = WORD_BITS,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_FASTEST
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Port enable pin
    input wire logic port_enable_pin,
    // Bit clock pin
    output logic bitClockOut,
    output logic bitClockOe,
    // Serial output pins
    output logic serial_out_line,
    output logic serialOutOe,
    output logic out_frame_sync,
    output logic outFrameSyncOe,
    // Serial input pins
    input wire logic serial_in_line,
    input wire logic in_frame_sync,
    // Words to transmit
    input wire logic [WIDTH-1:0] txWord,
    input wire logic txValid,
    output logic txReady,
    // Received data words
    output logic [WIDTH-1:0] rxWord,
    output logic rxValid,
    // Converter controls
    output logic reference_level_select,
    output logic [1:0] rateSelect,
    output logic sampleStrobe
);

    initial begin
        if (WIDTH != WORD_BITS) begin
            $error("adc_framed_serial_port: word width must be 16");
        end
        if (SAMPLE_CYCLES < 2 || SAMPLE_CYCLES > 8000) begin
            $error("adc_framed_serial_port: SAMPLE_CYCLES out of range");
        end
    end

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SYNC,
        TX_SHIFT
    } tx_state_type;

    // ==========================================================
    // Declarations
    // ==========================================================
    logic enMeta;
    logic enabled;
    logic fsMeta;
    logic fsSync;
    logic sdMeta;
    logic sdSync;
    logic [7:0] ctrlA;
    logic [7:0] ctrlB;
    logic [7:0] ctrlC;
    logic [7:0] sclkBase;
    logic [BIT_PERIOD_W-1:0] bitPeriod;
    logic bitClock;
    logic riseTick;
    logic fallTick;
    logic [WIDTH-1:0] fifoData;
    logic fifoValid;
    logic fifoReady;
    logic fifoInReady;
    tx_state_type txState;
    logic [WIDTH-1:0] txShift;
    logic [BIT_COUNT_W-1:0] txCount;
    logic txStart;
    logic rxActive;
    logic [WIDTH-1:0] rxShift;
    logic [BIT_COUNT_W-1:0] rxCount;
    logic [WIDTH-1:0] rxFull;
    logic rxDone;
    logic [15:0] sampleCount;
    logic [15:0] samplePeriod;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Port enable is asynchronous to the master clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enMeta <= 1'b0;
            enabled <= 1'b0;
        end else begin
            enMeta <= port_enable_pin;
            enabled <= enMeta;
        end
    end

    // Serial inputs come from the partner's clock domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fsMeta <= 1'b0;
            fsSync <= 1'b0;
            sdMeta <= 1'b0;
            sdSync <= 1'b0;
        end else begin
            fsMeta <= in_frame_sync;
            fsSync <= fsMeta;
            sdMeta <= serial_in_line;
            sdSync <= sdMeta;
        end
    end

    // ==========================================================
    // Bit clock generation
    // ==========================================================
    // Period is (master divider + 1) times serial divider, in clk cycles
    assign sclkBase = SCLK_BASE_DIV << ctrlA[SDIV_MSB:SDIV_LSB];
    assign bitPeriod = BIT_PERIOD_W'(12'({1'b0, ctrlA[MDIV_MSB:MDIV_LSB]} + 4'h1)
        * 12'(sclkBase));

    // Divider restarts from zero and stands still while disabled
    bit_clock_divider #(
        .PW(BIT_PERIOD_W)
    ) divider (
        .clk(clk),
        .rst_n(rst_n),
        .run(enabled),
        .period(bitPeriod),
        .bitClock(bitClock),
        .riseTick(riseTick),
        .fallTick(fallTick)
    );

    // Bit clock pin follows the divider and floats while disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bitClockOut <= 1'b0;
            bitClockOe <= 1'b0;
        end else begin
            bitClockOut <= bitClock;
            bitClockOe <= enabled;
        end
    end

    // ==========================================================
    // Transmit buffer
    // ==========================================================
    // Words queued here survive a disable period, except a head word popped by txStart in the first disabled cycle
    word_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) txFifo (
        .clk(clk),
        .rst_n(rst_n),
        .inData(txWord),
        .inValid(txValid),
        .inReady(fifoInReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(fifoReady)
    );

    assign txReady = fifoInReady;

    // A new frame may open from idle or on the last bit of the previous word
    assign txStart = riseTick && fifoValid && (txState == TX_IDLE
        || (txState == TX_SHIFT && txCount == '0));
    assign fifoReady = txStart;

    // ==========================================================
    // Transmit sequencer
    // ==========================================================
    // Apart from enable changes, all transmit pins change only on a bit clock rising edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txState <= TX_IDLE;
            txShift <= '0;
            txCount <= '0;
        end else if (!enabled) begin
            txState <= TX_IDLE;
            txCount <= '0;
        end else if (riseTick) begin
            unique case (txState)
                TX_IDLE: begin
                    if (txStart) begin
                        txShift <= fifoData;
                        txState <= TX_SYNC;
                    end
                end
                TX_SYNC: begin
                    txCount <= BIT_COUNT_W'(WIDTH - 1);
                    txState <= TX_SHIFT;
                end
                TX_SHIFT: begin
                    if (txCount == '0) begin
                        if (txStart) begin
                            txShift <= fifoData;
                            txState <= TX_SYNC;
                        end else begin
                            txState <= TX_IDLE;
                        end
                    end else begin
                        txShift <= {txShift[WIDTH-2:0], 1'b0};
                        txCount <= txCount - 1'b1;
                    end
                end
            endcase
        end
    end

    // Frame sync pin: one bit period high before each MSB
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_frame_sync <= 1'b0;
            outFrameSyncOe <= 1'b0;
        end else begin
            outFrameSyncOe <= enabled;
            if (!enabled) begin
                out_frame_sync <= 1'b0;
            end else if (riseTick) begin
                out_frame_sync <= txStart;
            end
        end
    end

    // Data pin: MSB first, driven only while a word is on the line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out_line <= 1'b0;
            serialOutOe <= 1'b0;
        end else if (!enabled) begin
            serial_out_line <= 1'b0;
            serialOutOe <= 1'b0;
        end else if (riseTick) begin
            if (txState == TX_SYNC) begin
                serial_out_line <= txShift[WIDTH-1];
                serialOutOe <= 1'b1;
            end else if (txState == TX_SHIFT && txCount != '0) begin
                serial_out_line <= txShift[WIDTH-2];
                serialOutOe <= 1'b1;
            end else begin
                serial_out_line <= 1'b0;
                serialOutOe <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Receive sequencer
    // ==========================================================
    // Frame sync and data are taken on the falling edge, and only when enabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxActive <= 1'b0;
            rxShift <= '0;
            rxCount <= '0;
        end else if (!enabled) begin
            rxActive <= 1'b0;
            rxCount <= '0;
        end else if (fallTick) begin
            if (!rxActive) begin
                if (fsSync) begin
                    rxActive <= 1'b1;
                    rxCount <= BIT_COUNT_W'(WIDTH - 1);
                end
            end else begin
                rxShift <= {rxShift[WIDTH-2:0], sdSync};
                rxCount <= rxCount - 1'b1;
                if (rxCount == '0) begin
                    rxActive <= 1'b0;
                end
            end
        end
    end

    // Completed word including the bit being captured now
    assign rxFull = {rxShift[WIDTH-2:0], sdSync};
    assign rxDone = enabled && fallTick && rxActive && rxCount == '0;

    // Data words go to the user side as a one-cycle pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxWord <= '0;
            rxValid <= 1'b0;
        end else begin
            rxValid <= rxDone && !rxFull[CTRL_FLAG_BIT];
            if (rxDone && !rxFull[CTRL_FLAG_BIT]) begin
                rxWord <= rxFull;
            end
        end
    end

    // ==========================================================
    // Control registers
    // ==========================================================
    // Written by control words; only the device reset clears them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlA <= CTRL_A_RESET;
            ctrlB <= CTRL_B_RESET;
            ctrlC <= CTRL_C_RESET;
        end else if (rxDone && rxFull[CTRL_FLAG_BIT]) begin
            unique case (rxFull[CTRL_ADDR_MSB:CTRL_ADDR_LSB])
                ADDR_CTRL_A: ctrlA <= rxFull[7:0];
                ADDR_CTRL_B: ctrlB <= rxFull[7:0];
                ADDR_CTRL_C: ctrlC <= rxFull[7:0];
                default: ctrlC <= ctrlC; // Unmapped addresses change nothing
            endcase
        end
    end

    // Converter control outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reference_level_select <= 1'b0;
            rateSelect <= 2'h0;
        end else begin
            reference_level_select <= ctrlC[REF_SEL_BIT];
            rateSelect <= ctrlB[RATE_MSB:RATE_LSB];
        end
    end

    // ==========================================================
    // Conversion rate timer
    // ==========================================================
    // Rate code 0..3 gives 64, 32, 16 and 8 kHz
    assign samplePeriod = 16'(SAMPLE_CYCLES) << rateSelect;

    // Strobe once per output sample period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sampleCount <= '0;
            sampleStrobe <= 1'b0;
        end else if (sampleCount >= samplePeriod - 16'h0001) begin
            sampleCount <= '0;
            sampleStrobe <= 1'b1;
        end else begin
            sampleCount <= sampleCount + 16'h0001;
            sampleStrobe <= 1'b0;
        end
    end

endmodule : adc_framed_serial_port

//--- adc_framed_serial_port_assertions.sv
`timescale 1ns/100ps

module adc_framed_serial_port_checker
    import adc_serial_port_pkg::*;
#(
    parameter int WIDTH = WORD_BITS,
    parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_FASTEST
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic port_enable_pin,
    // Link pins
    input wire logic bitClockOut,
    input wire logic bitClockOe,
    input wire logic serial_out_line,
    input wire logic serialOutOe,
    input wire logic out_frame_sync,
    input wire logic outFrameSyncOe,
    // User side
    input wire logic [WIDTH-1:0] rxWord,
    input wire logic rxValid,
    input wire logic reference_level_select,
    input wire logic [1:0] rateSelect,
    input wire logic sampleStrobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Strobe spacing
    // ==========================================================
    int gap;
    logic armed;

    // Cycles since last strobe, armed only over a steady rate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 0;
            armed <= 1'b0;
        end else begin
            gap <= sampleStrobe ? 1 : gap + 1;
            if ($changed(rateSelect) || !port_enable_pin) begin
                armed <= 1'b0;
            end else if (sampleStrobe) begin
                armed <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    chk_clock_half_period: assert property (
        $fell(bitClockOut) && port_enable_pin && $past(port_enable_pin, 4)
        |-> $past(bitClockOut, 4)) else $error("bit clock high too short");
    chk_data_on_rise: assert property (
        serialOutOe && $past(serialOutOe) && $changed(serial_out_line)
        |-> $rose(bitClockOut)) else $error("serial data changed off rise");
    chk_sync_on_rise: assert property (
        $changed(out_frame_sync) && outFrameSyncOe && port_enable_pin
        |-> $rose(bitClockOut)) else $error("frame sync changed off rise");
    chk_sync_before_msb: assert property (
        $fell(out_frame_sync) && port_enable_pin
        |-> serialOutOe && $past(out_frame_sync, 8)) else $error("frame sync not before word");
    chk_pins_float_off: assert property (
        !port_enable_pin [*5]
        |-> !serialOutOe && !outFrameSyncOe && !bitClockOe && !bitClockOut)
        else $error("pins driven while disabled");
    chk_ctrl_held_off: assert property (
        !port_enable_pin [*3]
        |=> $stable(reference_level_select) && $stable(rateSelect))
        else $error("control changed while disabled");
    chk_rx_data_pulse: assert property (
        rxValid |-> !rxWord[WIDTH-1] ##1 !rxValid) else $error("bad received word pulse");
    chk_strobe_spacing: assert property (
        sampleStrobe && armed |-> gap == (SAMPLE_CYCLES << rateSelect))
        else $error("sample strobe spacing wrong");

    // Main scenarios reached
    cover property ($fell(out_frame_sync));
    cover property (rxValid);
    cover property ($rose(reference_level_select));
    cover property ($fell(port_enable_pin));

endmodule : adc_framed_serial_port_checker

bind adc_framed_serial_port adc_framed_serial_port_checker #(
    .WIDTH(WIDTH), .SAMPLE_CYCLES(SAMPLE_CYCLES)
) chk (
    .clk(clk), .rst_n(rst_n), .port_enable_pin(port_enable_pin),
    .bitClockOut(bitClockOut), .bitClockOe(bitClockOe),
    .serial_out_line(serial_out_line), .serialOutOe(serialOutOe),
    .out_frame_sync(out_frame_sync), .outFrameSyncOe(outFrameSyncOe),
    .rxWord(rxWord), .rxValid(rxValid),
    .reference_level_select(reference_level_select),
    .rateSelect(rateSelect), .sampleStrobe(sampleStrobe)
);

//--- dsp_port_model.sv
`timescale 1ns/100ps

module dsp_port_model (
    // Link pins as seen on the wires
    input wire logic bitClk,
    input wire logic dataIn,
    input wire logic fsIn,
    output logic inFs,
    output logic inData
);
    int bitsLeft = 0;
    logic [15:0] shiftReg = 16'h0;
    // Every device word heard, oldest first
    logic [15:0] heard[$];

    initial begin
        inFs = 1'b0;
        inData = 1'b0;
    end

    // Sends one word: sync one period ahead, then MSB first on rises
    task automatic send_word(input logic [15:0] w);
        @(posedge bitClk);
        inFs = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            @(posedge bitClk);
            inFs = 1'b0;
            inData = w[i];
        end
        @(posedge bitClk);
        inData = ~w[0]; // Released line shows no stale value
    endtask : send_word

    // Captures device words on falling edges after a sync period
    always @(negedge bitClk) begin
        if (bitsLeft > 0) begin
            shiftReg = {shiftReg[14:0], dataIn};
            bitsLeft--;
            if (bitsLeft == 0) begin
                heard.push_back(shiftReg);
            end
        end else if (fsIn === 1'b1) begin
            bitsLeft = 16;
        end
    end

endmodule : dsp_port_model

//--- adc_framed_serial_port_tb.sv
`timescale 1ns/100ps

module adc_framed_serial_port_tb
    import adc_serial_port_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic portEnable = 1'b1;
    logic [WORD_BITS-1:0] txWord = 16'h0;
    logic txValid = 1'b0;
    logic bitClockOut, bitClockOe, serialOut, serialOutOe, outFs, outFsOe;
    logic txReady, rxValid, refSel, sampleStrobe, inFs, inData;
    logic [WORD_BITS-1:0] rxWord;
    logic [1:0] rateSelect;
    wire sdoWire = serialOutOe ? serialOut : 1'bz;
    wire fsWire = outFsOe ? outFs : 1'bz;
    int nFail = 0;
    int checksDone = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    adc_framed_serial_port #(.SAMPLE_CYCLES(20)) dut (
        .clk(clk), .rst_n(rst_n), .port_enable_pin(portEnable),
        .bitClockOut(bitClockOut), .bitClockOe(bitClockOe),
        .serial_out_line(serialOut), .serialOutOe(serialOutOe),
        .out_frame_sync(outFs), .outFrameSyncOe(outFsOe),
        .serial_in_line(inData), .in_frame_sync(inFs),
        .txWord(txWord), .txValid(txValid), .txReady(txReady),
        .rxWord(rxWord), .rxValid(rxValid), .reference_level_select(refSel),
        .rateSelect(rateSelect), .sampleStrobe(sampleStrobe)
    );

    dsp_port_model partner (
        .bitClk(bitClockOut), .dataIn(sdoWire), .fsIn(fsWire), .inFs(inFs),
        .inData(inData)
    );

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            nFail++;
            $display("ERROR timeout expected finish seen hang");
            wrapUp();
        end
    end

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic push(input logic [15:0] w);
        @(negedge clk);
        txWord = w;
        txValid = 1'b1;
        do @(posedge clk); while (txReady !== 1'b1);
        @(negedge clk);
        txValid = 1'b0;
    endtask : push

    task automatic wait_heard(input int n);
        while (partner.heard.size() < n) @(posedge clk);
    endtask : wait_heard

    task automatic wrapUp();
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrapUp

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic test_reset();
        check("txReady", 16'(txReady), 16'h1);
        check("refSel", 16'(refSel), 16'h0);
        check("rateSelect", 16'(rateSelect), 16'h0);
        check("serialOutOe", 16'(serialOutOe), 16'h0);
        $display("test reset done");
    endtask : test_reset

    task automatic test_tx_back_to_back();
        push(16'h8001);
        push(16'h7ffe);
        wait_heard(2);
        check("word0", partner.heard[0], 16'h8001);
        check("word1", partner.heard[1], 16'h7ffe);
        $display("test tx back to back done");
    endtask : test_tx_back_to_back

    task automatic test_control();
        realtime t;
        partner.send_word(16'h8001);
        repeat (8) @(posedge clk);
        @(posedge bitClockOut);
        t = $realtime;
        @(posedge bitClockOut);
        check("bitPeriod", 16'(int'(($realtime - t) / 25.0)), 16'h10);
        for (int r = 0; r < 4; r++) begin
            partner.send_word(16'h8100 | 16'(r));
            repeat (8) @(posedge clk);
            check("rateSelect", 16'(rateSelect), 16'(r));
            repeat (350) @(posedge clk);
        end
        partner.send_word(16'h8280);
        repeat (8) @(posedge clk);
        check("refSel", 16'(refSel), 16'h1);
        partner.send_word(16'h8755);
        repeat (8) @(posedge clk);
        check("refSelUnmapped", 16'(refSel), 16'h1);
        check("rateUnmapped", 16'(rateSelect), 16'h3);
        $display("test control done");
    endtask : test_control

    task automatic test_rx_data();
        fork
            partner.send_word(16'h1234);
            do @(posedge clk); while (rxValid !== 1'b1);
        join
        check("rxWord", rxWord, 16'h1234);
        $display("test rx data done");
    endtask : test_rx_data

    task automatic test_disable();
        int base;
        base = partner.heard.size();
        @(negedge clk);
        portEnable = 1'b0;
        repeat (8) @(negedge clk);
        check("pinOes", {13'h0, bitClockOe, serialOutOe, outFsOe}, 16'h0);
        check("bitClock", 16'(bitClockOut), 16'h0);
        for (int i = 0; i < 16; i++) begin
            push(16'h0100 + 16'(i));
        end
        check("fifoFull", 16'(txReady), 16'h0);
        @(negedge clk);
        portEnable = 1'b1;
        repeat (4) @(negedge clk);
        check("refKept", 16'(refSel), 16'h1);
        check("rateKept", 16'(rateSelect), 16'h3);
        wait_heard(base + 16);
        for (int i = 0; i < 16; i++) begin
            check("drained", partner.heard[base + i], 16'h0100 + 16'(i));
        end
        check("txReadyBack", 16'(txReady), 16'h1);
        $display("test disable done");
    endtask : test_disable

    // Main sequence
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        test_reset();
        test_tx_back_to_back();
        test_control();
        test_rx_data();
        test_disable();
        wrapUp();
    end

endmodule : adc_framed_serial_port_tb
